// file: core/caf_cfg.svh
// constants for the acceptance filter and bit quantum block
`ifndef CAF_CFG_SVH
`define CAF_CFG_SVH
`define CAF_ID_W        29
`define CAF_NFILT       16
`define CAF_NLEG        6
`define CAF_NMASK       3
`define CAF_BRP_W       6
`define CAF_SEG_W       3
`define CAF_SJW_W       2
`define CAF_TQ_FIXDIV   2
`define CAF_BT_MIN_TQ   8
`define CAF_BT_MAX_TQ   25
`define CAF_HIT_ROLL0   3'h6
`define CAF_HIT_ROLL1   3'h7
`define CAF_MSEL_M0     2'h0
`define CAF_MSEL_M1     2'h1
`define CAF_MSEL_F15    2'h2
`define CAF_MSEL_NONE   2'h3
`define CAF_F15         4'hf
`define CAF_FILT_F1     4'h1
`define CAF_BUF_ZERO    4'h0
`define CAF_BUF_ONE     4'h1
`endif

// file: core/caf_pkg.sv
// types for the acceptance filter and bit quantum block
`include "caf_cfg.svh"
package caf_pkg;
    typedef enum logic [1:0] {CAF_LEGACY, CAF_ENHANCED, CAF_FIFO} caf_mode_e;
    typedef enum logic [1:0] {CAF_SYNC, CAF_PROP, CAF_PH1, CAF_PH2} caf_seg_e;
    typedef struct packed {
        logic                  valid;
        logic [`CAF_ID_W-1:0]  ident;
    } caf_msg_s;
    typedef struct packed {
        logic                  load;
        logic [3:0]            buffer;
        logic [4:0]            hit;
    } caf_result_s;
    typedef struct packed {
        logic [`CAF_BRP_W-1:0] prescale;
        logic [`CAF_SEG_W-1:0] prop_len;
        logic [`CAF_SEG_W-1:0] ph1_len;
        logic [`CAF_SEG_W-1:0] ph2_len;
        logic [`CAF_SJW_W-1:0] sjw;
    } caf_timing_s;
    typedef struct packed {
        caf_result_s           res;
        logic [`CAF_BRP_W-1:0] pre_cnt;
        logic                  half;
        logic                  tq_tick;
        caf_seg_e              seg;
        logic [4:0]            seg_cnt;
        logic [4:0]            ph1_ext;
        logic [4:0]            ph2_cut;
        logic                  synced;
        logic                  rx_prev;
        logic                  sample_val;
        logic                  sample_tick;
        logic                  bit_start;
    } caf_state_s;
endpackage

// file: core/caf_filter.sv
// acceptance filtering and time quantum / bit timing generation
`timescale 1ns/1ps

module caf_filter
    import caf_pkg::*;
#(
    parameter int ID_W  = `CAF_ID_W,
    parameter int NFILT = `CAF_NFILT
) (
    input  wire logic                    mclk,
    input  wire logic                    srst,
    input  wire logic                    config_mode,
    input  caf_mode_e                    op_mode,
    input  wire logic                    cfg_we,
    input  wire logic [NFILT*ID_W-1:0]   filter_wdata,
    input  wire logic [NFILT-1:0]        filter_enable_bit,
    input  wire logic [NFILT*4-1:0]      filter_buffer_assoc_reg,
    input  wire logic [NFILT*2-1:0]      mask_select_reg,
    input  wire logic [ID_W-1:0]         accept_mask_zero_wdata,
    input  wire logic [ID_W-1:0]         accept_mask_one_wdata,
    input  wire logic                    f15_is_mask,
    input  wire logic                    buffer_zero_rollover_enable,
    input  wire logic                    buffer_zero_full,
    input  caf_msg_s                     message_assembly_buffer,
    input  caf_timing_s                  timing,
    input  wire logic                    rx_bit,
    output caf_result_s                  result,
    output logic                         tq_tick,
    output logic                         sample_tick,
    output logic                         sample_val,
    output logic                         bit_start
);
    caf_state_s              st_r;
    caf_state_s              st_nxt;
    logic [ID_W-1:0]         filt_r  [NFILT];
    logic [ID_W-1:0]         mask0_r;
    logic [ID_W-1:0]         mask1_r;
    logic [NFILT-1:0]        match;
    logic [ID_W-1:0]         eff_mask [NFILT];
    logic                    legacy;

    assign legacy = (op_mode == CAF_LEGACY);

    // stored only in configuration mode so a frame never sees a half-written set
    always_ff @(posedge mclk) begin
        if (srst) begin
            mask0_r <= '0;
            mask1_r <= '0;
            for (int i = 0; i < NFILT; i++) begin
                filt_r[i] <= '0;
            end
        end else if (cfg_we && config_mode) begin
            mask0_r <= accept_mask_zero_wdata;
            mask1_r <= accept_mask_one_wdata;
            for (int i = 0; i < NFILT; i++) begin
                filt_r[i] <= filter_wdata[i*ID_W +: ID_W];
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < NFILT; g++) begin : g_filt
            logic       en;
            logic [1:0] sel;
            assign sel = mask_select_reg[g*2 +: 2];
            always_comb begin
                if (legacy) begin
                    eff_mask[g] = (g < 2) ? mask0_r : mask1_r;
                end else begin
                    unique case (sel)
                        `CAF_MSEL_M0:  eff_mask[g] = mask0_r;
                        `CAF_MSEL_M1:  eff_mask[g] = mask1_r;
                        `CAF_MSEL_F15: eff_mask[g] = f15_is_mask ? filt_r[NFILT-1] : '0;
                        `CAF_MSEL_NONE: eff_mask[g] = '0;
                    endcase
                end
            end
            // legacy uses filters 0..5 always on; fifteen acting as mask never filters
            assign en = legacy ? (g < `CAF_NLEG)
                               : (filter_enable_bit[g] && !(g == NFILT-1 && f15_is_mask));
            // per bit: mask 0 accepts, mask 1 needs equality
            assign match[g] = en &&
                (((filt_r[g] ^ message_assembly_buffer.ident) & eff_mask[g]) == '0);
        end
    endgenerate

    function automatic logic [4:0] lowest(input logic [NFILT-1:0] m);
        logic [4:0] r;
        r = '0;
        for (int i = NFILT-1; i >= 0; i--) begin
            if (m[i]) begin
                r = 5'(i);
            end
        end
        return r;
    endfunction

    always_comb begin
        logic [4:0] win;
        logic [3:0] s;
        win = lowest(match);
        s = 4'd0;
        st_nxt = st_r;
        st_nxt.res.load = 1'b0;
        st_nxt.tq_tick = 1'b0;
        st_nxt.sample_tick = 1'b0;
        st_nxt.bit_start = 1'b0;
        if (message_assembly_buffer.valid && (|match)) begin
            st_nxt.res.load = 1'b1;
            if (legacy) begin
                if (win[3:0] <= `CAF_FILT_F1) begin
                    if (buffer_zero_full && buffer_zero_rollover_enable) begin
                        st_nxt.res.buffer = `CAF_BUF_ONE;
                        st_nxt.res.hit = {2'b00, win[0] ? `CAF_HIT_ROLL1 : `CAF_HIT_ROLL0};
                    end else begin
                        st_nxt.res.buffer = `CAF_BUF_ZERO;
                        st_nxt.res.hit = win;
                    end
                end else begin
                    st_nxt.res.buffer = `CAF_BUF_ONE;
                    st_nxt.res.hit = {2'b00, win[2:0]};
                end
            end else begin
                st_nxt.res.buffer = filter_buffer_assoc_reg[win[3:0]*4 +: 4];
                st_nxt.res.hit = win;
            end
        end

        // quantum: fixed divide by two after prescale+1, on the system clock
        st_nxt.half = st_r.half;
        if (st_r.pre_cnt == timing.prescale) begin
            st_nxt.pre_cnt = '0;
            st_nxt.half = ~st_r.half;
            st_nxt.tq_tick = st_r.half;
        end else begin
            st_nxt.pre_cnt = st_r.pre_cnt + 1'b1;
        end

        // falling (recessive to dominant) edge; one sync per bit
        st_nxt.rx_prev = rx_bit;
        if (st_r.rx_prev && !rx_bit && !st_r.synced && (rx_bit != st_r.sample_val)) begin
            st_nxt.synced = 1'b1;
            unique case (st_r.seg)
                CAF_PROP, CAF_PH1: st_nxt.ph1_ext = 5'(timing.sjw) + 5'd1;
                CAF_PH2: begin
                    st_nxt.ph2_cut = 5'(timing.sjw) + 5'd1;
                end
                CAF_SYNC: ;
            endcase
        end

        if (st_r.tq_tick) begin
            unique case (st_r.seg)
                CAF_SYNC: begin
                    st_nxt.seg = CAF_PROP;
                    st_nxt.seg_cnt = '0;
                end
                CAF_PROP: begin
                    if (st_r.seg_cnt == 5'(timing.prop_len)) begin
                        st_nxt.seg = CAF_PH1;
                        st_nxt.seg_cnt = '0;
                    end else begin
                        st_nxt.seg_cnt = st_r.seg_cnt + 5'd1;
                    end
                end
                CAF_PH1: begin
                    if (st_r.seg_cnt >= 5'(timing.ph1_len) + st_r.ph1_ext) begin
                        st_nxt.seg = CAF_PH2;
                        st_nxt.seg_cnt = '0;
                        st_nxt.sample_tick = 1'b1;
                        st_nxt.sample_val = rx_bit;
                        st_nxt.ph1_ext = '0;
                    end else begin
                        st_nxt.seg_cnt = st_r.seg_cnt + 5'd1;
                    end
                end
                CAF_PH2: begin
                    if (st_r.seg_cnt + st_r.ph2_cut >= 5'(timing.ph2_len)) begin
                        st_nxt.seg = CAF_SYNC;
                        st_nxt.seg_cnt = '0;
                        st_nxt.ph2_cut = '0;
                        // an edge in this very cycle belongs to the new bit, so the set wins
                        st_nxt.synced = st_nxt.synced & ~st_r.synced;
                        st_nxt.bit_start = 1'b1;
                    end else begin
                        st_nxt.seg_cnt = st_r.seg_cnt + 5'd1;
                    end
                end
            endcase
            st_nxt.seg_cnt = st_nxt.seg_cnt + 5'(s);
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            st_r <= '0;
            st_r.sample_val <= 1'b1;
            st_r.rx_prev <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign result      = st_r.res;
    assign tq_tick     = st_r.tq_tick;
    assign sample_tick = st_r.sample_tick;
    assign sample_val  = st_r.sample_val;
    assign bit_start   = st_r.bit_start;

    // limitation: bit-rate ceiling depends on software choosing prescale and segments
    chk_load_needs_match: assert property (@(posedge mclk) disable iff (srst)
        st_r.res.load |-> $past(message_assembly_buffer.valid && (|match)))
        else $error("load without a valid matching message");
    chk_mask_zero_accepts: assert property (@(posedge mclk) disable iff (srst)
        (!legacy && filter_enable_bit[0] && mask_select_reg[1:0] == `CAF_MSEL_NONE
         && !(f15_is_mask && NFILT == 1)) |-> match[0])
        else $error("unmasked enabled filter did not accept");
    chk_mask_set_compare: assert property (@(posedge mclk) disable iff (srst)
        (match[0] && !legacy && mask_select_reg[1:0] == `CAF_MSEL_M0)
        |-> (((filt_r[0] ^ message_assembly_buffer.ident) & mask0_r) == '0))
        else $error("masked bit mismatch accepted");
    chk_disabled_quiet: assert property (@(posedge mclk) disable iff (srst)
        (!legacy && !filter_enable_bit[2]) |-> !match[2])
        else $error("disabled filter matched");
    chk_filters_frozen: assert property (@(posedge mclk) disable iff (srst)
        !config_mode |=> $stable(mask0_r) && $stable(mask1_r))
        else $error("mask changed outside configuration mode");
    chk_legacy_hit: assert property (@(posedge mclk) disable iff (srst)
        (st_r.res.load && legacy && st_r.res.buffer == `CAF_BUF_ONE) |-> st_r.res.hit <= 5'd7)
        else $error("legacy hit code out of range");
    chk_lowest_wins: assert property (@(posedge mclk) disable iff (srst)
        (message_assembly_buffer.valid && !legacy && match[0]) |=> st_r.res.hit == 5'd0)
        else $error("higher filter took priority over filter zero");
    chk_sync_one_tq: assert property (@(posedge mclk) disable iff (srst)
        (st_r.tq_tick && st_r.seg == CAF_SYNC) |=> st_r.seg == CAF_PROP)
        else $error("sync segment longer than one quantum");
    chk_quantum_gap: assert property (@(posedge mclk) disable iff (srst)
        (st_r.tq_tick && timing.prescale == '0) |=> !st_r.tq_tick ##1 st_r.tq_tick)
        else $error("quantum period not two clocks at prescale zero");
endmodule

// file: sim/caf_bus_node.sv
// far-side bus node that sends bit-stuffed frames onto the receive line
`timescale 1ns/1ps
module caf_bus_node (
    input  wire logic        mclk,
    input  wire logic        send,
    input  wire logic [15:0] payload,
    input  wire logic [15:0] bit_clks,
    output logic             rx_bit = 1'b1,
    output logic             busy = 1'b0
);
    logic [16:0] sh;
    int          cnt, run, left;
    // the line idles recessive; a frame opens with a dominant start bit
    always @(posedge mclk) begin
        if (send && !busy) begin
            sh   <= {1'b0, payload};
            cnt  <= 0;
            run  <= 0;
            left <= 17;
            busy <= 1'b1;
        end else if (busy && cnt != 0) begin
            cnt <= cnt - 1;
        end else if (busy) begin
            cnt <= int'(bit_clks) - 1;
            if (run == 5) begin
                rx_bit <= ~rx_bit;
                run    <= 1;
            end else if (left != 0) begin
                rx_bit <= sh[16];
                run    <= (sh[16] == rx_bit) ? run + 1 : 1;
                sh     <= sh << 1;
                left   <= left - 1;
            end else begin
                rx_bit <= 1'b1;
                busy   <= 1'b0;
            end
        end
    end
endmodule

// file: sim/testbench.sv
// self-checking bench: acceptance filtering, quantum and bit timing
`timescale 1ns/1ps
`include "caf_cfg.svh"
module testbench;
    import caf_pkg::*;
    localparam int NF = `CAF_NFILT;
    localparam int IW = `CAF_ID_W;
    logic             mclk = 1'b0, srst = 1'b1, config_mode = 1'b0, cfg_we = 1'b0;
    logic             f15 = 1'b0, roll = 1'b0, b0_full = 1'b0, send = 1'b0, chk_on = 1'b0;
    logic             tick_d = 1'b0, rx_last = 1'b1;
    logic             tq_tick, sample_tick, sample_val, bit_start, rx_bit, busy;
    caf_mode_e        op_mode = CAF_LEGACY;
    logic [NF*IW-1:0] fw = '0;
    logic [NF-1:0]    fen = '0;
    logic [NF*4-1:0]  assoc = '0;
    logic [NF*2-1:0]  msel = '0;
    logic [IW-1:0]    m0w = '0, m1w = '0, sm0, sm1;
    logic [IW-1:0]    sf [NF];
    logic [15:0]      payload = '0;
    caf_msg_s         msg = '0;
    caf_timing_s      timing = '0;
    caf_result_s      result, prev = '0;
    int               stable = 0, fails = 0, comparisons = 0;
    wire logic [2:0]  ev = {bit_start, sample_tick, tq_tick};

    caf_filter i_caf_filter (
        .mclk(mclk), .srst(srst), .config_mode(config_mode), .op_mode(op_mode), .cfg_we(cfg_we),
        .filter_wdata(fw), .filter_enable_bit(fen), .filter_buffer_assoc_reg(assoc),
        .mask_select_reg(msel), .accept_mask_zero_wdata(m0w), .accept_mask_one_wdata(m1w),
        .f15_is_mask(f15), .buffer_zero_rollover_enable(roll), .buffer_zero_full(b0_full),
        .message_assembly_buffer(msg), .timing(timing), .rx_bit(rx_bit), .result(result),
        .tq_tick(tq_tick), .sample_tick(sample_tick), .sample_val(sample_val), .bit_start(bit_start));
    // far node bit is three local bits long, so every sample sees a settled level
    caf_bus_node i_caf_bus_node (
        .mclk(mclk), .send(send), .payload(payload), .bit_clks(16'h0036), .rx_bit(rx_bit), .busy(busy));

    always #2.5 mclk = ~mclk;

    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wrap_up();
        if (fails == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // sparse words keep masks narrow so matches are common
    function automatic logic [IW-1:0] sparse();
        return IW'($urandom & $urandom & $urandom);
    endfunction

    function automatic caf_result_s exp_res(logic [IW-1:0] id);
        caf_result_s   r;
        logic [IW-1:0] m;
        logic          en, leg;
        r = '0;
        leg = (op_mode == CAF_LEGACY);
        for (int i = NF - 1; i >= 0; i--) begin
            case (msel[i*2+:2])
                2'h0: m = sm0;
                2'h1: m = sm1;
                2'h2: m = f15 ? sf[15] : '0;
                default: m = '0;
            endcase
            if (leg) m = (i < 2) ? sm0 : sm1;
            en = leg ? (i < `CAF_NLEG) : fen[i];
            if (en && ((id ^ sf[i]) & m) == '0) r = '{1'b1, leg ? 4'(i > 1) : assoc[i*4+:4], 5'(i)};
        end
        if (leg && r.load && r.hit < 5'h02 && roll && b0_full) r = '{1'b1, 4'h1, r.hit + 5'h06};
        return r;
    endfunction

    task automatic step(logic v, logic [IW-1:0] id);
        @(posedge mclk);
        msg <= '{v, id};
        #1;
        check("load", result.load, prev.load);
        if (prev.load) check("buffer", result.buffer, prev.buffer);
        if (prev.load) check("hit", result.hit, prev.hit);
        prev = v ? exp_res(id) : '0;
    endtask

    task automatic cfg(logic in_cfg);
        @(posedge mclk);
        config_mode <= in_cfg;
        cfg_we <= 1'b1;
        for (int i = 0; i < NF; i++) fw[i*IW+:IW] <= IW'($urandom);
        m0w <= sparse();
        m1w <= sparse();
        @(posedge mclk);
        cfg_we <= 1'b0;
        config_mode <= 1'b0;
        if (!in_cfg) return;
        for (int i = 0; i < NF; i++) sf[i] = fw[i*IW+:IW];
        sm0 = m0w;
        sm1 = m1w;
    endtask

    task automatic wait_ev(int k, output int n);
        n = 0;
        do begin
            @(posedge mclk);
            #1;
            n++;
        end while (ev[k] !== 1'b1 && n < 5000);
        if (n >= 5000) begin
            fails++;
            wrap_up();
        end
    endtask

    // reset restarts the counters so a new timing takes effect cleanly
    task automatic bit_time(int pre, int pr, int p1, int p2);
        int q, n;
        q = 2 * (pre + 1);
        @(posedge mclk);
        timing <= '{6'(pre), 3'(pr), 3'(p1), 3'(p2), 2'($urandom)};
        srst <= 1'b1;
        @(posedge mclk);
        srst <= 1'b0;
        wait_ev(0, n);
        wait_ev(0, n);
        check("tq gap", n, q);
        wait_ev(2, n);
        wait_ev(1, n);
        check("to sample", n, q * (3 + pr + p1));
        wait_ev(2, n);
        check("to bit", n, q * (p2 + 1));
        wait_ev(2, n);
        check("bit time", n, q * (4 + pr + p1 + p2));
    endtask

    task automatic frame(logic [15:0] p);
        int n;
        @(posedge mclk);
        payload <= p;
        send <= 1'b1;
        @(posedge mclk);
        send <= 1'b0;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (busy !== 1'b0 && n < 3000);
        if (n >= 3000) begin
            fails++;
            wrap_up();
        end
        repeat (100) @(posedge mclk);
    endtask

    always @(posedge mclk) begin
        rx_last <= rx_bit;
        stable <= (rx_bit === rx_last) ? stable + 1 : 0;
        tick_d <= sample_tick;
        // rx_last is the level the sample saw; rx_bit may already show the next far bit
        if (chk_on && tick_d === 1'b1 && stable > 30) check("sample", sample_val, rx_last);
    end

    initial begin
        int f;
        void'($urandom(90));
        repeat (8) @(posedge mclk);
        srst <= 1'b0;
        for (int ph = 0; ph < 7; ph++) begin
            @(posedge mclk);
            op_mode <= (ph < 3) ? CAF_LEGACY : (ph[0] ? CAF_ENHANCED : CAF_FIFO);
            f = $urandom_range(1);
            f15 <= f[0];
            roll <= (ph != 0);
            b0_full <= (ph == 2);
            fen <= NF'($urandom) & {~f[0], 15'h7fff};
            assoc <= {$urandom, $urandom};
            msel <= $urandom;
            cfg(ph < 6);
            for (int j = 0; j < 48; j++)
                step(1'b1, (j % 8 == 7) ? IW'($urandom) : sf[$urandom_range(NF - 1)] ^ sparse());
            step(1'b0, '0);
        end
        bit_time(0, 1, 1, 2);
        bit_time(63, 7, 7, 7);
        for (int t = 0; t < 4; t++)
            bit_time($urandom_range(3), $urandom_range(7, 2), $urandom_range(7, 1), $urandom_range(7, 1));
        bit_time(0, 1, 2, 2);
        chk_on <= 1'b1;
        frame(16'h0000);
        frame(16'hffff);
        for (int t = 0; t < 4; t++) frame(16'($urandom));
        wrap_up();
    end
endmodule
